// ---- core/mcr_consts.vh ----
`ifndef MCR_CONSTS_VH
`define MCR_CONSTS_VH

// ==========================================
// Register offsets
`define MCR_ADDR_STATUS      8'h3A
`define MCR_ADDR_OUT_CTRL    8'h3B
`define MCR_ADDR_VARIABLE    8'h3C
`define MCR_ADDR_SOFT_RESET  8'h3D
`define MCR_ADDR_TEMP_CTRL   8'h3E
`define MCR_ADDR_TEMP_RESULT 8'h3F
`define MCR_ADDR_TEMP_EXT    8'h40

// ==========================================
// Field positions
`define MCR_BIT_ALERT_FUNC   2
`define MCR_BIT_GEN_OUT      1
`define MCR_BIT_ALERT_LEVEL  0
`define MCR_BIT_CONV_ACTIVE  7
`define MCR_BIT_CONV_TRIG    2
`define MCR_BIT_REPEAT       1
`define MCR_BIT_COMP_SRC     0

// ==========================================
// Reset values and codes
`define MCR_RST_VARIABLE     8'h00
`define MCR_RST_TEMP_RESULT  8'h19
`define MCR_RST_TEMP_EXT     8'h00
`define MCR_SOFT_RESET_CODE  8'hFF
`define MCR_SOFT_RESET_READ  8'h03
`define MCR_TEMP_MAX         8'h59
`define MCR_TEMP_MIN         8'hDA

// ==========================================
// Timing
`define MCR_CLK_HZ           50000000
`define MCR_CONV_TIME_MS     20

`endif

// ---- core/mcr_regs.v ----
// Notes on behaviour
// - Alert pin is an interrupt output when its function select bit is 0, a plain output when 1.
// - As a plain output the alert pin is driven low for drive level 0 and high for 1.
// - In interrupt mode the alert pin is open drain, pulled low while an interrupt is pending.
// - The general output pin is push-pull and follows its control bit, which resets to 0.
// - An 8-bit read/write global variable resets to zero and is shared with the engines.
// - Writing all ones to the reset register returns every register to its default, except a status bit that its engine sets in the same cycle.
// - Reading the reset register always returns 00000011.
// - Bit 7 of the temperature control register reads 1 only while a conversion runs.
// - Each write of 1 to the trigger bit outside power-save starts a conversion whose result lands in 0x3F.
// - A conversion lasts about 20 ms at room temperature.
// - With sensor enabled and repeat set, conversions run back to back except in power-save.
// - With repeat clear, conversions start only on a trigger write, at start-up or on leaving power-save.
// - The compensation source bit picks 0x3F when 0 and 0x40 when 1.
// - Reading the status register clears engine interrupt bits and frees the alert pin.
// - Temperatures are 8-bit two's complement, clamped to -38..89 degrees.
`timescale 1ns/1ns
`include "mcr_consts.vh"

module mcr_regs
#(
    parameter        CONV_CYCLES = `MCR_CONV_TIME_MS * (`MCR_CLK_HZ / 1000),
    parameter        TIMER_W     = 20,
    parameter        ENGINES     = 3
)
(
    input  wire              clock_i,
    input  wire              rst_n_i,
    input  wire              reg_wr_i,
    input  wire              reg_rd_i,
    input  wire [7:0]        reg_addr_i,
    input  wire [7:0]        reg_wdata_i,
    output reg  [7:0]        reg_rdata_o,
    input  wire [ENGINES-1:0] eng_int_set_i,
    input  wire              var_wr_i,
    input  wire [7:0]        var_wdata_i,
    output wire [7:0]        program_variable_o,
    input  wire              chip_startup_i,
    input  wire              powersave_i,
    input  wire [7:0]        temp_sense_i,
    output wire [7:0]        comp_temp_o,
    output reg               soft_reset_o,
    output wire              general_output_pin_o,
    output wire              alert_pin_o,
    output wire              alert_pin_oe_o
);

    // ==========================================
    // Decode
    localparam integer       CONV_END  = CONV_CYCLES - 1;
    localparam [TIMER_W-1:0] CONV_LAST = CONV_END[TIMER_W-1:0];
    localparam [1:0]         ST_IDLE   = 2'b01;
    localparam [1:0]         ST_CONV   = 2'b10;

    reg  [1:0]          state;
    reg  [TIMER_W-1:0]  timer;
    reg                 alert_func;
    reg                 alert_level;
    reg                 gen_out;
    reg  [7:0]          variable;
    reg                 conv_enable;
    reg                 repeat_sel;
    reg                 comp_src;
    reg  [7:0]          temp_result;
    reg  [7:0]          temp_ext;
    reg  [ENGINES-1:0]  eng_int;
    reg  [7:0]          sense_meta;
    reg  [7:0]          sense_sync;
    reg                 powersave_d;
    reg  [7:0]          next_rdata;

    wire wr_out   = reg_wr_i && (reg_addr_i == `MCR_ADDR_OUT_CTRL);
    wire wr_var   = reg_wr_i && (reg_addr_i == `MCR_ADDR_VARIABLE);
    wire wr_ctrl  = reg_wr_i && (reg_addr_i == `MCR_ADDR_TEMP_CTRL);
    wire wr_ext   = reg_wr_i && (reg_addr_i == `MCR_ADDR_TEMP_EXT);
    wire rd_stat  = reg_rd_i && (reg_addr_i == `MCR_ADDR_STATUS);
    // Only the exact all-ones code resets; other values fall through
    wire soft_clr = reg_wr_i && (reg_addr_i == `MCR_ADDR_SOFT_RESET)
                    && (reg_wdata_i == `MCR_SOFT_RESET_CODE);
    wire busy     = state[1];

    // Clamp a signed reading into the compensation range
    function [7:0] clamp_temp;
        input [7:0] t;
        begin
            if ($signed(t) > $signed(`MCR_TEMP_MAX))
                clamp_temp = `MCR_TEMP_MAX;
            else if ($signed(t) < $signed(`MCR_TEMP_MIN))
                clamp_temp = `MCR_TEMP_MIN;
            else
                clamp_temp = t;
        end
    endfunction

    // ==========================================
    // Conversion start sources
    wire trig_write = wr_ctrl && reg_wdata_i[`MCR_BIT_CONV_TRIG];
    wire ps_exit    = powersave_d && !powersave_i;
    wire auto_start = conv_enable && (chip_startup_i || ps_exit);
    wire rep_start  = conv_enable && repeat_sel && !powersave_i;
    wire conv_start = (trig_write || auto_start || rep_start) && !powersave_i;

    // ==========================================
    // Sensor word crosses in from the analog side
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sense_meta  <= 8'h00;
            sense_sync  <= 8'h00;
            powersave_d <= 1'b0;
        end
        else
        begin
            sense_meta  <= temp_sense_i;
            sense_sync  <= sense_meta;
            powersave_d <= powersave_i;
        end
    end

    // ==========================================
    // Conversion timer, one-hot state
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state       <= ST_IDLE;
            timer       <= {TIMER_W{1'b0}};
            temp_result <= `MCR_RST_TEMP_RESULT;
        end
        else if (soft_clr)
        begin
            state       <= ST_IDLE;
            timer       <= {TIMER_W{1'b0}};
            temp_result <= `MCR_RST_TEMP_RESULT;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    timer <= {TIMER_W{1'b0}};
                    if (conv_start)
                        state <= ST_CONV;
                end
                ST_CONV:
                begin
                    // Power-save aborts; a fresh trigger outranks the period end
                    if (powersave_i)
                    begin
                        state <= ST_IDLE;
                    end
                    else if (trig_write)
                        timer <= {TIMER_W{1'b0}};
                    else if (timer == CONV_LAST)
                    begin
                        temp_result <= clamp_temp(sense_sync);
                        state       <= ST_IDLE;
                    end
                    else
                        timer <= timer + 1'b1;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================
    // Control and data registers
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            alert_func  <= 1'b0;
            alert_level <= 1'b0;
            gen_out     <= 1'b0;
            variable    <= `MCR_RST_VARIABLE;
            conv_enable <= 1'b0;
            repeat_sel  <= 1'b0;
            comp_src    <= 1'b0;
            temp_ext    <= `MCR_RST_TEMP_EXT;
        end
        else if (soft_clr)
        begin
            alert_func  <= 1'b0;
            alert_level <= 1'b0;
            gen_out     <= 1'b0;
            variable    <= `MCR_RST_VARIABLE;
            conv_enable <= 1'b0;
            repeat_sel  <= 1'b0;
            comp_src    <= 1'b0;
            temp_ext    <= `MCR_RST_TEMP_EXT;
        end
        else
        begin
            if (wr_out)
            begin
                alert_func  <= reg_wdata_i[`MCR_BIT_ALERT_FUNC];
                gen_out     <= reg_wdata_i[`MCR_BIT_GEN_OUT];
                alert_level <= reg_wdata_i[`MCR_BIT_ALERT_LEVEL];
            end
            // Host write wins over an engine write in the same cycle
            if (wr_var)
                variable <= reg_wdata_i;
            else if (var_wr_i)
                variable <= var_wdata_i;
            if (wr_ctrl)
            begin
                conv_enable <= reg_wdata_i[`MCR_BIT_CONV_TRIG];
                repeat_sel  <= reg_wdata_i[`MCR_BIT_REPEAT];
                comp_src    <= reg_wdata_i[`MCR_BIT_COMP_SRC];
            end
            if (wr_ext)
                temp_ext <= clamp_temp(reg_wdata_i);
        end
    end

    // ==========================================
    // Engine interrupt flags, set wins over read-clear
    genvar g;
    generate
        for (g = 0; g < ENGINES; g = g + 1)
        begin : g_int
            always @(posedge clock_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                    eng_int[g] <= 1'b0;
                else if (eng_int_set_i[g])
                    eng_int[g] <= 1'b1;
                else if (rd_stat || soft_clr)
                    eng_int[g] <= 1'b0;
            end
        end
    endgenerate

    // ==========================================
    // Read mux, answered one cycle after the strobe
    always @*
    begin
        next_rdata = 8'h00;
        case (reg_addr_i)
            `MCR_ADDR_STATUS:
                next_rdata[ENGINES-1:0] = eng_int;
            `MCR_ADDR_OUT_CTRL:
            begin
                next_rdata[`MCR_BIT_ALERT_FUNC]  = alert_func;
                next_rdata[`MCR_BIT_GEN_OUT]     = gen_out;
                next_rdata[`MCR_BIT_ALERT_LEVEL] = alert_level;
            end
            `MCR_ADDR_VARIABLE:
                next_rdata = variable;
            `MCR_ADDR_SOFT_RESET:
                next_rdata = `MCR_SOFT_RESET_READ;
            `MCR_ADDR_TEMP_CTRL:
            begin
                next_rdata[`MCR_BIT_CONV_ACTIVE] = busy;
                next_rdata[`MCR_BIT_CONV_TRIG]   = conv_enable;
                next_rdata[`MCR_BIT_REPEAT]      = repeat_sel;
                next_rdata[`MCR_BIT_COMP_SRC]    = comp_src;
            end
            `MCR_ADDR_TEMP_RESULT:
                next_rdata = temp_result;
            `MCR_ADDR_TEMP_EXT:
                next_rdata = temp_ext;
            default:
                next_rdata = 8'h00;
        endcase
    end

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            reg_rdata_o  <= 8'h00;
            soft_reset_o <= 1'b0;
        end
        else
        begin
            if (reg_rd_i)
                reg_rdata_o <= next_rdata;
            soft_reset_o <= soft_clr;
        end
    end

    // ==========================================
    // Pins and shared values
    assign program_variable_o   = variable;
    assign comp_temp_o          = comp_src ? temp_ext : temp_result;
    assign general_output_pin_o = gen_out;
    // Interrupt mode only ever drives low, so the wire needs its pull-up
    assign alert_pin_o    = alert_func ? alert_level : 1'b0;
    assign alert_pin_oe_o = alert_func ? 1'b1 : (|eng_int);

endmodule // mcr_regs

// ---- test/mcr_regs_checker.sv ----
`timescale 1ns/1ns
// ==========================================
// Port checker for the control register bank
module mcr_regs_checker
#(
    parameter ENGINES = 3
)
(
    input wire logic               clock_i,
    input wire logic               rst_n_i,
    input wire logic               reg_wr_i,
    input wire logic               reg_rd_i,
    input wire logic [7:0]         reg_addr_i,
    input wire logic [7:0]         reg_wdata_i,
    input wire logic [7:0]         reg_rdata_o,
    input wire logic [ENGINES-1:0] eng_int_set_i,
    input wire logic               powersave_i,
    input wire logic [7:0]         program_variable_o,
    input wire logic               soft_reset_o,
    input wire logic               general_output_pin_o,
    input wire logic               alert_pin_o,
    input wire logic               alert_pin_oe_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // Pin mode and variable writes and the interrupt pull-down, checked one cycle after the taking edge
    AST_ALERT_OUT: assert property (reg_wr_i && reg_addr_i == 8'h3B && reg_wdata_i[2]
        |=> alert_pin_oe_o && alert_pin_o == $past(reg_wdata_i[0])) else $error("alert output");
    AST_ALERT_OE: assert property ((|eng_int_set_i) && !reg_wr_i && !alert_pin_oe_o
        && !alert_pin_o |=> alert_pin_oe_o && !alert_pin_o) else $error("alert not pulled");
    AST_GEN_OUT: assert property (reg_wr_i && reg_addr_i == 8'h3B
        |=> general_output_pin_o == $past(reg_wdata_i[1])) else $error("general pin");
    AST_VAR: assert property (reg_wr_i && reg_addr_i == 8'h3C
        |=> program_variable_o == $past(reg_wdata_i)) else $error("variable not stored");
    // Soft reset pulses only for the all ones code
    AST_SOFT_PULSE: assert property (reg_wr_i && reg_addr_i == 8'h3D && reg_wdata_i == 8'hFF
        |=> soft_reset_o) else $error("soft reset missing");
    AST_SOFT_IGNORE: assert property (reg_wr_i && reg_addr_i == 8'h3D && reg_wdata_i != 8'hFF
        |=> !soft_reset_o) else $error("soft reset spurious");
    AST_RST_READ: assert property (reg_rd_i && reg_addr_i == 8'h3D
        |=> reg_rdata_o == 8'h03) else $error("reset register read");
    // A fresh trigger shows busy on a read two cycles later
    AST_BUSY: assert property (reg_wr_i && reg_addr_i == 8'h3E && reg_wdata_i[2] && !powersave_i
        ##1 !reg_wr_i && !powersave_i ##1 reg_rd_i && reg_addr_i == 8'h3E && !reg_wr_i && !powersave_i
        |=> reg_rdata_o[7]) else $error("busy flag low");
endmodule // mcr_regs_checker

// ---- test/mcr_host.sv ----
`timescale 1ns/1ns
// ==========================================
// Host side of the register port
module mcr_host
(
    input  wire logic       clock_i,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic [7:0]      reg_addr_o,
    output logic [7:0]      reg_wdata_o,
    input  wire logic [7:0] reg_rdata_i
);
    // Idle bus at time zero
    initial
    begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'hA5;
        reg_wdata_o = 8'h5A;
    end

    // One access; lines inverted on release so no stale value lingers
    task xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    begin
        @(posedge clock_i);
        reg_wr_o <= wr;
        reg_rd_o <= !wr;
        reg_addr_o <= a;
        reg_wdata_o <= d;
        @(posedge clock_i);
        reg_wr_o <= 1'b0;
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
        #1;
        q = reg_rdata_i;
    end
    endtask
endmodule // mcr_host

// ---- test/test_mcr_regs.sv ----
`timescale 1ns/1ns
// ==========================================
// Bench for the control register bank
module test_mcr_regs;
    logic       clock_i, rst_n_i, reg_wr_i, reg_rd_i, var_wr_i, chip_startup_i, powersave_i;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, var_wdata_i, program_variable_o;
    logic [7:0] temp_sense_i, comp_temp_o, d, r;
    logic [2:0] eng_int_set_i;
    logic       soft_reset_o, general_output_pin_o, alert_pin_o, alert_pin_oe_o;
    integer     seed, miscompares, total_checks;

    mcr_regs #(.CONV_CYCLES(16), .TIMER_W(20), .ENGINES(3)) uut (.clock_i(clock_i),
        .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .eng_int_set_i(eng_int_set_i),
        .var_wr_i(var_wr_i), .var_wdata_i(var_wdata_i), .program_variable_o(program_variable_o),
        .chip_startup_i(chip_startup_i), .powersave_i(powersave_i), .temp_sense_i(temp_sense_i),
        .comp_temp_o(comp_temp_o), .soft_reset_o(soft_reset_o),
        .general_output_pin_o(general_output_pin_o), .alert_pin_o(alert_pin_o),
        .alert_pin_oe_o(alert_pin_oe_o));
    mcr_host h (.clock_i(clock_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
        .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));

    // 50 MHz clock
    initial
    begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    // One compare for every result
    task chk(input logic [7:0] e, input logic [7:0] g);
    begin
        total_checks++;
        if (g !== e)
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        if (g !== e)
            miscompares++;
    end
    endtask

    // Expected clamp of a two's complement temperature
    function automatic logic [7:0] exp_clamp(input logic [7:0] t);
        if ($signed(t) > 8'sh59)
            return 8'h59;
        else if ($signed(t) < 8'shDA)
            return 8'hDA;
        else
            return t;
    endfunction

    task wrap_up;
    begin
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask

    // Pulse engine interrupt, engine variable write and start-up inputs together for one cycle
    task pulse_eng(input logic [2:0] e);
    begin
        @(posedge clock_i);
        eng_int_set_i <= e;
        var_wr_i <= 1'b1;
        chip_startup_i <= 1'b1;
        @(posedge clock_i);
        eng_int_set_i <= 3'h0;
        var_wr_i <= 1'b0;
        chip_startup_i <= 1'b0;
        #1;
    end
    endtask

    // Main sequence
    initial
    begin
        seed = 46;
        miscompares = 0;
        total_checks = 0;
        {rst_n_i, var_wr_i, chip_startup_i, powersave_i, eng_int_set_i} = 7'h00;
        var_wdata_i = 8'hC3;
        temp_sense_i = 8'h7F;
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        h.xfer(0, 8'h3C, 8'h00, r); chk(8'h00, r);
        h.xfer(0, 8'h3D, 8'h00, r); chk(8'h03, r);
        chk(8'h19, comp_temp_o);
        chk(8'h00, {alert_pin_oe_o, general_output_pin_o});
        h.xfer(0, 8'h55, 8'h00, r); chk(8'h00, r);
        // Random pin modes, variable values and harmless reset codes
        repeat (8)
        begin
            d = 8'($random(seed));
            h.xfer(1, 8'h3B, d, r);
            chk({d[2], d[1], d[2] & d[0]}, {alert_pin_oe_o, general_output_pin_o, alert_pin_o});
            h.xfer(1, 8'h3C, d, r);
            h.xfer(1, 8'h3D, d & 8'hFE, r);
            h.xfer(0, 8'h3D, 8'h00, r); chk(8'h03, r);
            h.xfer(1, 8'h40, d, r);
            h.xfer(0, 8'h40, 8'h00, r); chk(exp_clamp(d), r);
            h.xfer(0, 8'h3C, 8'h00, r); chk(d, r);
        end
        // Engine write of the variable and an engine interrupt
        h.xfer(1, 8'h3B, 8'h00, r);
        pulse_eng(3'h4);
        chk(8'hC3, program_variable_o);
        chk(8'h02, {alert_pin_oe_o, alert_pin_o});
        h.xfer(0, 8'h3A, 8'h00, r); chk(8'h04, r);
        chk(8'h00, {alert_pin_oe_o, alert_pin_o});
        // Single conversion, result clamped, then compensation source
        h.xfer(1, 8'h3E, 8'h04, r);
        h.xfer(0, 8'h3E, 8'h00, r); chk(8'h84, r);
        repeat (20) @(posedge clock_i);
        h.xfer(0, 8'h3E, 8'h00, r); chk(8'h04, r);
        h.xfer(0, 8'h3F, 8'h00, r); chk(8'h59, r);
        chk(exp_clamp(8'h7F), comp_temp_o);
        // Start-up pulse restarts a conversion while enabled
        pulse_eng(3'h0);
        h.xfer(0, 8'h3E, 8'h00, r); chk(8'h84, r);
        h.xfer(1, 8'h40, 8'h80, r);
        h.xfer(1, 8'h3E, 8'h01, r); chk(exp_clamp(8'h80), comp_temp_o);
        // Repeat mode, suspended in power-save, restart on exit
        h.xfer(1, 8'h3E, 8'h06, r);
        h.xfer(0, 8'h3E, 8'h00, r); chk(8'h86, r);
        // Past the end of the first period, repeat mode is busy again
        repeat (15) @(posedge clock_i);
        h.xfer(0, 8'h3E, 8'h00, r); chk(8'h86, r);
        @(posedge clock_i) powersave_i <= 1'b1;
        h.xfer(1, 8'h3E, 8'h04, r);
        h.xfer(0, 8'h3E, 8'h00, r); chk(8'h04, r);
        @(posedge clock_i) powersave_i <= 1'b0;
        h.xfer(0, 8'h3E, 8'h00, r); chk(8'h84, r);
        // Soft reset clears everything, conversion included
        h.xfer(1, 8'h3B, 8'h02, r);
        h.xfer(1, 8'h3D, 8'hFF, r);
        h.xfer(0, 8'h3C, 8'h00, r); chk(8'h00, r);
        h.xfer(0, 8'h3E, 8'h00, r); chk(8'h00, r);
        chk(8'h00, {general_output_pin_o, alert_pin_oe_o});
        wrap_up;
    end

    // Watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        #400000;
        miscompares++;
        wrap_up;
    end
endmodule // test_mcr_regs

bind mcr_regs mcr_regs_checker #(.ENGINES(ENGINES)) u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .eng_int_set_i(eng_int_set_i), .powersave_i(powersave_i),
    .program_variable_o(program_variable_o), .soft_reset_o(soft_reset_o),
    .general_output_pin_o(general_output_pin_o), .alert_pin_o(alert_pin_o),
    .alert_pin_oe_o(alert_pin_oe_o));
